// file: rtl/demand_dma_channel.sv
// General channel: moves words or bytes between DRAM and a demand-driven peripheral.
// Assumes a DRAM arbiter answering dram_req with a one-cycle dram_gnt (read data valid
// with it) and an external bus arbiter answering ext_bus_req with ext_bus_gnt.
//
// Notes on behaviour
// - Channel starts only on a transfer count write; configuration alone starts nothing.
// - A zero count is accepted and completes at once; software should avoid it.
// - Toward peripheral: fetch DRAM first, then serve each request from the latch.
// - Toward DRAM: wait request, run bus cycle into latch, then write DRAM once granted.
// - Transfers repeat until count exhausted, bad address, or flush.
// - Flush sets done flag; software waits for it before reprogramming.
// - Word writes assert both byte strobes; byte writes only the lower one.
// - Bytes are packed into and unpacked from words, big endian.
// - Request sensing is level or edge with polarity; default active low level.
// - Acknowledge output is always active low.
// - Synchronise request, win external bus, acknowledge, run cycle, release acknowledge.
// - A setting chooses whether bank select asserts during channel bus cycles.
// - Acknowledge timing equals bank select timing during a channel access.
// - DRAM read requested when latch can accept data; write once a word, two bytes or a last odd byte is latched.
// - Count reaching zero without error sets done and terminal count flags.
// - Unmapped address stops channel, sets bad address flag, parks in error.
// - Soft reset clears control logic, the error state and the done and terminal count flags, not settings.
// - Flush writes pending receive data to DRAM, discards pending send data.
// - Flush coinciding with normal completion sets both done and terminal count.
// - Sense field: 00 low level, 01 high level, 10 falling, 11 rising.
// - Size bit set means bytes; direction bit set means DRAM to peripheral.
// - Fourteen-bit count of units, decremented after each destination transfer.
`timescale 1ns/1ps
module demand_dma_channel
  import dma_channel_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               resetn,
  // Settings, held by the register file outside
  input  wire logic               dir_to_periph,
  input  wire logic               byte_size,
  input  wire logic [1:0]         request_sense_mode,
  input  wire logic               select_during_transfer,
  input  wire logic [addr_w-1:0]  dram_start_addr,
  input  wire logic               count_write,
  input  wire logic [count_w-1:0] count_value,
  input  wire logic               flush_request,
  input  wire logic               general_channel_soft_reset,
  // Status
  output logic                    busy,
  output logic                    latch_full,
  output logic [count_w-1:0]      count_remaining,
  output logic                    transfer_done_flag,
  output logic                    terminal_count_flag,
  output logic                    bad_address_flag,
  // DRAM bus
  output logic                    dram_req,
  output logic                    dram_we,
  output logic [addr_w-1:0]       dram_addr,
  output logic [data_w-1:0]       dram_wdata,
  input  wire logic               dram_gnt,
  input  wire logic [data_w-1:0]  dram_rdata,
  input  wire logic               dram_addr_bad,
  // External bus
  output logic                    ext_bus_req,
  input  wire logic               ext_bus_gnt,
  input  wire logic               ext_bank_bad,
  input  wire logic               peripheral_request_in,
  output logic                    peripheral_ack_out_n,
  output logic                    bank_select_n,
  output logic                    upper_byte_write_strobe_n,
  output logic                    lower_byte_write_strobe_n,
  output logic                    read_strobe_n,
  output logic [data_w-1:0]       ext_data_out,
  output logic                    ext_data_oe_n,
  input  wire logic [data_w-1:0]  ext_data_in
);

  chan_state_t        state_q;
  chan_state_t        state_d;
  logic [count_w-1:0] count_q;
  logic [addr_w-1:0]  addr_q;
  logic [data_w-1:0]  latch_q;
  logic [data_w-1:0]  out_q;
  logic [1:0]         units_q;
  logic               flush_pend_q;
  logic               done_q;
  logic               tc_q;
  logic               bad_q;

  logic               req_active;
  logic               req_take;
  logic               cyc_start;
  logic               cyc_busy;
  logic               cyc_last;
  logic               start_ok;
  logic               fetch_ok;
  logic               ext_ok;
  logic               wr_ok;
  logic               finish;
  logic               finish_tc;
  logic               fault;
  logic [1:0]         units_after;
  logic [count_w-1:0] count_after;

  function automatic logic [count_w-1:0] count_less(input logic [count_w-1:0] c, input logic [1:0] n);
    count_less = c - count_w'(n);
  endfunction : count_less

  request_sense request_sense_inst (
    .clk        (clk),
    .resetn     (resetn),
    .soft_reset (general_channel_soft_reset),
    .pin        (peripheral_request_in),
    .mode       (request_sense_mode),
    .take       (req_take),
    .active     (req_active)
  );

  ext_cycle_timer ext_cycle_timer_inst (
    .clk        (clk),
    .resetn     (resetn),
    .soft_reset (general_channel_soft_reset),
    .start      (cyc_start),
    .busy       (cyc_busy),
    .last       (cyc_last)
  );

  // Count writes while the channel is working are ignored
  assign start_ok = count_write && (state_q == st_idle);
  assign fetch_ok = (state_q == st_fetch) && dram_gnt && !dram_addr_bad;
  assign ext_ok   = (state_q == st_ext_cyc) && cyc_last;
  assign wr_ok    = (state_q == st_dram_wr) && dram_gnt && !dram_addr_bad;
  assign req_take = (state_q == st_wait_req) && req_active && !flush_pend_q;
  assign cyc_start = (state_q == st_ext_arb) && ext_bus_gnt && !ext_bank_bad;

  // Units left in or gathered by the latch after this step
  always_comb begin
    units_after = units_q;
    count_after = count_q;
    if (ext_ok && dir_to_periph) begin
      units_after = units_q - 2'h1;
      count_after = count_less(count_q, 2'h1);
    end else if (ext_ok) begin
      units_after = units_q + 2'h1;
    end else if (wr_ok) begin
      units_after = 2'h0;
      count_after = count_less(count_q, byte_size ? units_q : 2'h1);
    end
  end

  always_comb begin
    state_d   = state_q;
    finish    = 1'b0;
    finish_tc = 1'b0;
    fault     = 1'b0;
    unique case (state_q)
      st_idle: begin
        if (start_ok && count_value == count_rst) begin
          finish    = 1'b1;
          finish_tc = 1'b1;
        end else if (start_ok) begin
          state_d = dir_to_periph ? st_fetch : st_wait_req;
        end
      end
      st_fetch: begin
        if (flush_pend_q) begin
          state_d = st_idle;
          finish  = 1'b1;
        end else if (dram_gnt && dram_addr_bad) begin
          state_d = st_halt;
          fault   = 1'b1;
        end else if (dram_gnt) begin
          state_d = st_wait_req;
        end
      end
      st_wait_req: begin
        if (flush_pend_q && !dir_to_periph && units_q != 2'h0) begin
          state_d = st_dram_wr;
        end else if (flush_pend_q) begin
          state_d = st_idle;
          finish  = 1'b1;
        end else if (req_active) begin
          state_d = st_ext_arb;
        end
      end
      st_ext_arb: begin
        if (ext_bus_gnt && ext_bank_bad) begin
          state_d = st_halt;
          fault   = 1'b1;
        end else if (ext_bus_gnt) begin
          state_d = st_ext_cyc;
        end
      end
      st_ext_cyc: begin
        if (cyc_last && dir_to_periph) begin
          if (count_after == count_rst) begin
            state_d   = st_idle;
            finish    = 1'b1;
            finish_tc = 1'b1;
          end else if (flush_pend_q) begin
            state_d = st_idle;
            finish  = 1'b1;
          end else begin
            state_d = (units_after == 2'h0) ? st_fetch : st_wait_req;
          end
        end else if (cyc_last) begin
          // Word, two bytes, or the last odd byte go straight to DRAM
          if (!byte_size || units_after == 2'h2 || count_w'(units_after) == count_q || flush_pend_q) begin
            state_d = st_dram_wr;
          end else begin
            state_d = st_wait_req;
          end
        end
      end
      st_dram_wr: begin
        if (dram_gnt && dram_addr_bad) begin
          state_d = st_halt;
          fault   = 1'b1;
        end else if (dram_gnt && count_after == count_rst) begin
          state_d   = st_idle;
          finish    = 1'b1;
          finish_tc = 1'b1;
        end else if (dram_gnt && flush_pend_q) begin
          state_d = st_idle;
          finish  = 1'b1;
        end else if (dram_gnt) begin
          state_d = st_wait_req;
        end
      end
      st_halt: begin
        state_d = st_halt;
      end
      default: begin
        state_d = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= st_idle;
    end else if (general_channel_soft_reset) begin
      state_q <= st_idle;
    end else begin
      state_q <= state_d;
    end
  end

  // Flush is only meaningful while a transfer runs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flush_pend_q <= 1'b0;
    end else if (general_channel_soft_reset || finish || fault) begin
      flush_pend_q <= 1'b0;
    end else if (flush_request && state_q != st_idle && state_q != st_halt) begin
      flush_pend_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= count_rst;
      addr_q  <= addr_rst;
    end else if (start_ok) begin
      count_q <= count_value;
      addr_q  <= dram_start_addr;
    end else begin
      count_q <= count_after;
      if (fetch_ok || wr_ok) begin
        addr_q <= addr_q + addr_w'(1);
      end
    end
  end

  // Latch and packing; a byte transfer keeps the first byte in the high lane
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latch_q <= latch_rst;
      units_q <= units_rst;
    end else if (general_channel_soft_reset || finish || start_ok) begin
      latch_q <= latch_rst;
      units_q <= units_rst;
    end else if (fetch_ok) begin
      // A lone last byte moves to the low lane, where a single-unit send reads it
      latch_q <= (byte_size && count_q == count_w'(1)) ? {8'h00, dram_rdata[hi_lsb +: 8]} : dram_rdata;
      units_q <= (byte_size && count_q != count_w'(1)) ? 2'h2 : 2'h1;
    end else if (ext_ok && !dir_to_periph) begin
      units_q <= units_after;
      if (!byte_size) begin
        latch_q <= ext_data_in;
      end else if (units_q == 2'h0) begin
        // Low lane cleared so an odd last byte is written with a zero partner
        latch_q <= {ext_data_in[lo_lsb +: 8], 8'h00};
      end else begin
        latch_q[lo_lsb +: 8] <= ext_data_in[lo_lsb +: 8];
      end
    end else if (ext_ok || wr_ok) begin
      units_q <= units_after;
    end
  end

  // Output data is registered at cycle start; bytes go out on the low lane
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_q <= latch_rst;
    end else if (cyc_start && !byte_size) begin
      out_q <= latch_q;
    end else if (cyc_start) begin
      out_q <= {8'h00, (units_q == 2'h2) ? latch_q[hi_lsb +: 8] : latch_q[lo_lsb +: 8]};
    end
  end

  // Status flags: a new event wins over the clear of a fresh start
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done_q <= 1'b0;
      tc_q   <= 1'b0;
      bad_q  <= 1'b0;
    end else if (general_channel_soft_reset) begin
      done_q <= 1'b0;
      tc_q   <= 1'b0;
      bad_q  <= 1'b0;
    end else begin
      done_q <= finish || (done_q && !start_ok);
      tc_q   <= finish_tc || (tc_q && !start_ok);
      bad_q  <= fault || bad_q;
    end
  end

  assign busy                = (state_q != st_idle) && (state_q != st_halt);
  assign latch_full          = (units_q != 2'h0);
  assign count_remaining     = count_q;
  assign transfer_done_flag  = done_q;
  assign terminal_count_flag = tc_q;
  assign bad_address_flag    = bad_q;

  assign dram_req   = ((state_q == st_fetch) && !flush_pend_q) || (state_q == st_dram_wr);
  assign dram_we    = (state_q == st_dram_wr);
  assign dram_addr  = addr_q;
  assign dram_wdata = latch_q;

  assign ext_bus_req = (state_q == st_ext_arb);

  // Acknowledge and bank select come from one window so their timing matches
  assign peripheral_ack_out_n      = !cyc_busy;
  assign bank_select_n             = !(cyc_busy && select_during_transfer);
  assign upper_byte_write_strobe_n = !(cyc_busy && dir_to_periph && !byte_size);
  assign lower_byte_write_strobe_n = !(cyc_busy && dir_to_periph);
  assign read_strobe_n             = !(cyc_busy && !dir_to_periph);
  assign ext_data_out              = out_q;
  assign ext_data_oe_n             = !(cyc_busy && dir_to_periph);

endmodule : demand_dma_channel

// file: rtl/dma_channel_pkg.sv
// Package for the demand-driven channel: widths, encodings, states and timing counts.
// Assumes a single core clock at the rate given by clk_freq_mhz.
package dma_channel_pkg;

  localparam int count_w      = 14;
  localparam int addr_w       = 24;
  localparam int data_w       = 16;

  localparam int clk_freq_mhz = 125;
  // Length of one channel-generated external bus cycle, ns, rounded up to clocks
  localparam int ext_cycle_ns   = 32;
  localparam int ext_cycle_clks = (ext_cycle_ns * clk_freq_mhz + 999) / 1000;

  // Request sense encodings
  localparam logic [1:0] sense_low_level  = 2'h0;
  localparam logic [1:0] sense_high_level = 2'h1;
  localparam logic [1:0] sense_fall_edge  = 2'h2;
  localparam logic [1:0] sense_rise_edge  = 2'h3;

  // Reset values
  localparam logic              req_level_rst = 1'b1;
  localparam logic [count_w-1:0] count_rst    = 14'h0000;
  localparam logic [addr_w-1:0]  addr_rst     = 24'h00_0000;
  localparam logic [data_w-1:0]  latch_rst    = 16'h0000;
  localparam logic [1:0]         units_rst    = 2'h0;

  // Byte lanes of the 16-bit latch, big endian: first byte sits high
  localparam int hi_lsb = 8;
  localparam int lo_lsb = 0;

  typedef enum logic [2:0] {
    st_idle     = 3'h0,
    st_fetch    = 3'h1,
    st_wait_req = 3'h3,
    st_ext_arb  = 3'h2,
    st_ext_cyc  = 3'h6,
    st_dram_wr  = 3'h7,
    st_halt     = 3'h5
  } chan_state_t;

endpackage : dma_channel_pkg

// file: rtl/request_sense.sv
// Synchroniser and level/edge recogniser for the peripheral request pin.
// Assumes the pin is asynchronous; take pulses consume a latched edge.
`timescale 1ns/1ps
module request_sense
  import dma_channel_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       soft_reset,
  input  wire logic       pin,
  input  wire logic [1:0] mode,
  input  wire logic       take,
  output logic            active
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic edge_pend_q;
  logic fall;
  logic rise;

  // Three stages; a change counts once the last two agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= req_level_rst;
      s2_q <= req_level_rst;
      s3_q <= req_level_rst;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      level_q <= req_level_rst;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

  assign fall = (s2_q == s3_q) && level_q && !s3_q;
  assign rise = (s2_q == s3_q) && !level_q && s3_q;

  // A new edge in the cycle it is consumed is kept: set wins over take
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      edge_pend_q <= 1'b0;
    end else if ((mode == sense_fall_edge && fall) || (mode == sense_rise_edge && rise)) begin
      edge_pend_q <= 1'b1;
    end else if (take || soft_reset) begin
      edge_pend_q <= 1'b0;
    end
  end

  always_comb begin
    unique case (mode)
      sense_low_level:  active = !level_q;
      sense_high_level: active = level_q;
      sense_fall_edge:  active = edge_pend_q;
      sense_rise_edge:  active = edge_pend_q;
    endcase
  end

endmodule : request_sense

// file: rtl/ext_cycle_timer.sv
// Times one channel-generated external bus cycle.
// Acknowledge and bank select share the same window so they stay identical.
`timescale 1ns/1ps
module ext_cycle_timer
  import dma_channel_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic soft_reset,
  input  wire logic start,
  output logic      busy,
  output logic      last
);

  localparam int cnt_w = $clog2(ext_cycle_clks + 1);
  localparam logic [cnt_w-1:0] cycle_len = cnt_w'(ext_cycle_clks);

  logic [cnt_w-1:0] cnt_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else if (soft_reset) begin
      cnt_q <= '0;
    end else if (start) begin
      cnt_q <= cycle_len;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - cnt_w'(1);
    end
  end

  assign busy = (cnt_q != '0);
  assign last = (cnt_q == cnt_w'(1));

endmodule : ext_cycle_timer

// file: dv/demand_dma_channel_asserts.sv
// Checker for the demand channel: acknowledge window, strobes, DRAM requests and flags.
// Assumes it is bound to every demand_dma_channel instance; one clock domain.
`timescale 1ns/1ps
module demand_dma_channel_asserts
  import dma_channel_pkg::*;
(
  input wire logic               clk,
  input wire logic               resetn,
  input wire logic               dir_to_periph,
  input wire logic               byte_size,
  input wire logic               select_during_transfer,
  input wire logic               count_write,
  input wire logic               general_channel_soft_reset,
  input wire logic               busy,
  input wire logic               latch_full,
  input wire logic [count_w-1:0] count_remaining,
  input wire logic               transfer_done_flag,
  input wire logic               terminal_count_flag,
  input wire logic               bad_address_flag,
  input wire logic               dram_req,
  input wire logic               dram_we,
  input wire logic               dram_gnt,
  input wire logic               dram_addr_bad,
  input wire logic               ext_bus_gnt,
  input wire logic               ext_bank_bad,
  input wire logic               peripheral_ack_out_n,
  input wire logic               bank_select_n,
  input wire logic               upper_byte_write_strobe_n,
  input wire logic               lower_byte_write_strobe_n,
  input wire logic               read_strobe_n,
  input wire logic               ext_data_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_ack_gnt; $fell(peripheral_ack_out_n) |-> $past(ext_bus_gnt); endproperty
  a_ack_gnt: assert property (p_ack_gnt) else $error("ack without bus grant");
  property p_ack_len; $fell(peripheral_ack_out_n) |=> (!peripheral_ack_out_n) [*3] ##1 peripheral_ack_out_n; endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack window not four clocks");
  property p_sel; bank_select_n == (select_during_transfer ? peripheral_ack_out_n : 1'b1); endproperty
  a_sel: assert property (p_sel) else $error("bank select differs from ack");
  property p_upper; !upper_byte_write_strobe_n |-> !lower_byte_write_strobe_n && !byte_size; endproperty
  a_upper: assert property (p_upper) else $error("upper strobe in byte mode");
  property p_wr;
    !peripheral_ack_out_n && dir_to_periph |->
      !lower_byte_write_strobe_n && !ext_data_oe_n && upper_byte_write_strobe_n == byte_size;
  endproperty
  a_wr: assert property (p_wr) else $error("write cycle strobes wrong");
  property p_rd;
    !peripheral_ack_out_n && !dir_to_periph |-> !read_strobe_n && ext_data_oe_n && lower_byte_write_strobe_n;
  endproperty
  a_rd: assert property (p_rd) else $error("read cycle strobes wrong");
  property p_send_full; $fell(peripheral_ack_out_n) && dir_to_periph |-> latch_full; endproperty
  a_send_full: assert property (p_send_full) else $error("send cycle with empty latch");
  property p_dram; dram_req |-> (dram_we ? !dir_to_periph && latch_full : dir_to_periph && !latch_full); endproperty
  a_dram: assert property (p_dram) else $error("dram request kind wrong");
  property p_tc; $rose(terminal_count_flag) |-> transfer_done_flag && count_remaining == '0; endproperty
  a_tc: assert property (p_tc) else $error("terminal count without zero count");
  property p_bad;
    $rose(bad_address_flag) |-> !busy && ($past(dram_gnt) && $past(dram_addr_bad) || $past(ext_bus_gnt) && $past(ext_bank_bad));
  endproperty
  a_bad: assert property (p_bad) else $error("bad address flag without cause");
  property p_park; bad_address_flag && !general_channel_soft_reset |=> bad_address_flag && !busy; endproperty
  a_park: assert property (p_park) else $error("error state left without soft reset");
  property p_srst; general_channel_soft_reset |=> !bad_address_flag && !busy; endproperty
  a_srst: assert property (p_srst) else $error("soft reset did not idle");
  property p_start; $rose(busy) |-> $past(count_write); endproperty
  a_start: assert property (p_start) else $error("start without count write");

  c_tc: cover property ($rose(terminal_count_flag));
  c_bad: cover property ($rose(bad_address_flag));
  c_byte_wr: cover property ($fell(peripheral_ack_out_n) && byte_size && dir_to_periph);
endmodule : demand_dma_channel_asserts

bind demand_dma_channel demand_dma_channel_asserts demand_dma_channel_asserts_inst (.*);

// file: dv/periph_model.sv
// Demand peripheral: raises its request, sources read data, records write data.
// Assumes the bench enables it only while the channel is busy.
`timescale 1ns/1ps
module periph_model (
  input  wire logic        clk,
  input  wire logic        en,
  input  wire logic        pol,
  input  wire logic        ack_n,
  input  wire logic        oe_n,
  input  wire logic [15:0] dout,
  output logic             req,
  output logic [15:0]      din
);
  logic [15:0] sent [$];
  logic [15:0] got [$];
  logic [15:0] w;
  logic        want  = 1'b0;
  logic        ack_d = 1'b1;
  int          gap   = 0;
  assign req = pol ? want : ~want;
  initial din = 16'h0000;
  always @(posedge clk) begin
    ack_d <= ack_n;
    // Drop the request once served, so a level request does not start one cycle too many
    if (!ack_n) begin
      want <= 1'b0;
      gap  <= 2;
    end else if (gap > 0) gap <= gap - 1;
    else want <= en;
    if (!ack_n && ack_d) begin
      w = $urandom;
      if (oe_n) begin
        din <= w;
        sent.push_back(w);
      end else got.push_back(dout);
    end else if (ack_n && !ack_d) din <= ~din;
  end
endmodule : periph_model

// file: dv/tb_demand_dma_channel.sv
// Bench for the demand channel: DRAM and bus arbiters, peripheral model, queue-based expectations.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %0h got %0h", nm, e, s); end end
module tb_demand_dma_channel;
  import dma_channel_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, dir_to_periph = 1'b0, byte_size = 1'b0, select_during_transfer = 1'b0;
  logic count_write = 1'b0, flush_request = 1'b0, general_channel_soft_reset = 1'b0;
  logic dram_gnt = 1'b0, dram_addr_bad = 1'b0, ext_bus_gnt = 1'b0, ext_bank_bad = 1'b0, g, ext_bad = 1'b0;
  logic [1:0]         request_sense_mode = 2'h0;
  logic [addr_w-1:0]  dram_start_addr = 24'h00_0000;
  logic [count_w-1:0] count_value = 14'h0000;
  logic [data_w-1:0]  dram_rdata = 16'h0000;
  logic [15:0]        mem [0:255];
  wire logic busy, latch_full, transfer_done_flag, terminal_count_flag, bad_address_flag, dram_req, dram_we;
  wire logic ext_bus_req, peripheral_ack_out_n, bank_select_n, upper_byte_write_strobe_n, peripheral_request_in;
  wire logic lower_byte_write_strobe_n, read_strobe_n, ext_data_oe_n;
  wire logic [count_w-1:0] count_remaining;
  wire logic [addr_w-1:0]  dram_addr;
  wire logic [data_w-1:0]  dram_wdata, ext_data_out, ext_data_in;
  int n_mismatch = 0, checked = 0, lim = 999, m, d, b;

  demand_dma_channel demand_dma_channel_inst (.*);
  periph_model periph_model_inst (.clk(clk), .en(busy), .pol(request_sense_mode[0]), .ack_n(peripheral_ack_out_n),
    .oe_n(ext_data_oe_n), .dout(ext_data_out), .req(peripheral_request_in), .din(ext_data_in));

  initial forever #4 clk = ~clk;

  // Arbiters grant after a random delay; released read data shows the inverse
  always @(negedge clk) begin
    g = dram_req && !dram_gnt && ($urandom_range(1, 0) == 1);
    if (g && dram_we) mem[dram_addr[7:0]] = dram_wdata;
    dram_rdata <= g ? mem[dram_addr[7:0]] : ~dram_rdata;
    dram_addr_bad <= g && dram_addr >= lim;
    dram_gnt <= g;
    g = ext_bus_req && !ext_bus_gnt && ($urandom_range(1, 0) == 1);
    ext_bank_bad <= g && ext_bad;
    ext_bus_gnt <= g;
  end

  task automatic stop_test();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic run(input logic dr, bs, input logic [1:0] md, input int n, fl, bad);
    int k, u;
    logic [15:0] w;
    dir_to_periph = dr;
    byte_size = bs;
    request_sense_mode = md;
    select_during_transfer = 1'($urandom);
    dram_start_addr = 24'($urandom_range(60, 0));
    lim = bad == 1 ? dram_start_addr + 1 : 999;
    ext_bad = bad == 2;
    for (k = 0; k < 12; k++) mem[dram_start_addr + k] = 16'($urandom);
    periph_model_inst.sent.delete();
    periph_model_inst.got.delete();
    repeat (6) @(negedge clk);
    general_channel_soft_reset = 1'b1;
    @(negedge clk);
    general_channel_soft_reset = 1'b0;
    `CHK("bad flag", 1'b0, bad_address_flag)
    count_value = 14'(n);
    count_write = 1'b1;
    @(negedge clk);
    count_write = 1'b0;
    for (k = 0; k < 3000 && busy !== 1'b0; k++) begin
      flush_request = fl > 0 && k == fl;
      @(negedge clk);
    end
    flush_request = 1'b0;
    if (busy !== 1'b0) begin
      n_mismatch++;
      $display("unexpected busy exp 0 got %b", busy);
      stop_test();
    end
    repeat (2) @(negedge clk);
    if (bad != 0) begin
      `CHK("bad flag", 1'b1, bad_address_flag)
      count_write = 1'b1;
      @(negedge clk);
      count_write = 1'b0;
      @(negedge clk);
      `CHK("busy", 1'b0, busy)
    end else begin
      u = n - int'(count_remaining);
      if (fl == 0) `CHK("count left", 14'h0000, count_remaining)
      `CHK("done", 1'b1, transfer_done_flag)
      `CHK("tc", count_remaining == 0, terminal_count_flag)
      `CHK("units", u, dr ? periph_model_inst.got.size() : periph_model_inst.sent.size())
      for (k = 0; k < u; k++) begin
        if (dr) begin
          w = bs ? {8'h00, mem[dram_start_addr + k / 2][((k % 2) ? 0 : 8) +: 8]} : mem[dram_start_addr + k];
          `CHK("periph data", w, periph_model_inst.got[k])
        end else if (!bs) begin
          `CHK("dram word", periph_model_inst.sent[k], mem[dram_start_addr + k])
        end else if (k % 2 == 0) begin
          w = {periph_model_inst.sent[k][7:0], k + 1 < u ? periph_model_inst.sent[k + 1][7:0] : 8'h00};
          `CHK("dram pack", w, mem[dram_start_addr + k / 2])
        end
      end
    end
  endtask : run

  initial begin
    void'($urandom(26450));
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    repeat (10) @(negedge clk);
    `CHK("idle busy", 1'b0, busy)
    for (m = 0; m < 4; m++)
      for (d = 0; d < 2; d++)
        for (b = 0; b < 2; b++)
          run(d[0], b[0], m[1:0], $urandom_range(5, 1), 0, 0);
    run(1'b0, 1'b0, 2'h0, 0, 0, 0);
    run(1'b0, 1'b1, 2'h2, 9, 40, 0);
    run(1'b1, 1'b0, 2'h3, 9, 40, 0);
    run(1'b0, 1'b0, 2'h0, 4, 0, 1);
    run(1'b1, 1'b1, 2'h1, 4, 0, 2);
    stop_test();
  end
endmodule : tb_demand_dma_channel
